// >>> blbeu_pkg.sv
// Purpose: Shared constants and types for the bit logic and BCD execution unit.
// Assumes: APB slave at 125 MHz pclk, one word per register.
// Notes:   Register offsets, command and clock field positions, operand reset values and base cycle counts live here.
// Functional notes
// - One counted instruction clock is one CPU clock chosen by clock control.
// - Listed counts hold for internal ROM fetch; other fetch may add clocks.
// - Each external read wait state adds two CPU clocks.
// - Pointer-pair bit read-modify-write takes 16 plus 2n plus 2m clocks.
// - Operands outside high-speed RAM use the longer count, 14 not 12.
// - Decimal adjusts: 2 bytes, 8 clocks, packed BCD result, update Z, AC, CY; the subtract adjust here leaves CY unchanged.
// - Bit-and short-direct: CY = CY AND bit, 3 bytes, 12 clocks.
// - Bit-and SFR bit: CY = CY AND bit, 14 clocks only.
// - Bit-and accumulator bit: CY = CY AND bit, 2 bytes, 8 clocks.
// - Bit-and pointer-pair bit: 12 clocks, or 14 plus 2n outside.
// - Bit-or short-direct: CY = CY OR bit, 3 bytes, 12 clocks.
// - Bit-or status-word bit: CY = CY OR bit, 3 bytes, 14 clocks.
// - Bit-or pointer-pair bit: CY = CY OR bit, 12 clocks in fast RAM.
// - Bit-xor status-word bit: CY = CY XOR bit, 3 bytes, 14 clocks.
// - Bit-xor pointer-pair bit: 12 clocks, or 14 plus 2n outside.
package blbeu_pkg;

	localparam logic [7:0] OFS_CMD  = 8'h00;
	localparam logic [7:0] OFS_ACC  = 8'h04;
	localparam logic [7:0] OFS_PSW  = 8'h08;
	localparam logic [7:0] OFS_MEM  = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_CLK  = 8'h14;

	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_KIND_LSB = 4;
	localparam int CMD_BIT_LSB  = 8;
	localparam int CMD_HS_BIT   = 12;
	localparam int CMD_RDW_LSB  = 16;
	localparam int CMD_WRW_LSB  = 20;
	localparam int CLK_SEL_LSB  = 0;
	localparam int CLK_XF_BIT   = 4;

	localparam int PSW_CY_BIT = 0;
	localparam int PSW_AC_BIT = 4;
	localparam int PSW_Z_BIT  = 6;

	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] PSW_RST = 8'h00;
	localparam logic [7:0] MEM_RST = 8'h00;
	localparam logic [2:0] SEL_RST = 3'h0;

	localparam logic [7:0] CLK_SHORT  = 8'h08;
	localparam logic [7:0] CLK_HS     = 8'h0C;
	localparam logic [7:0] CLK_EXT    = 8'h0E;
	localparam logic [7:0] CLK_STORE  = 8'h10;
	localparam logic [7:0] WAIT_CLKS  = 8'h02;
	localparam logic [3:0] LEN_SHORT  = 4'h2;
	localparam logic [3:0] LEN_LONG   = 4'h3;

	typedef enum logic [2:0] {
		OP_LOAD  = 3'h0,
		OP_STORE = 3'h1,
		OP_AND   = 3'h2,
		OP_OR    = 3'h3,
		OP_XOR   = 3'h4,
		OP_SET   = 3'h5,
		OP_ADJA  = 3'h6,
		OP_ADJS  = 3'h7
	} blbeu_op_t;

	typedef enum logic [2:0] {
		K_SADDR = 3'h0,
		K_SFR   = 3'h1,
		K_ACC   = 3'h2,
		K_PSW   = 3'h3,
		K_HL    = 3'h4
	} blbeu_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} blbeu_state_t;

	typedef struct packed {
		blbeu_op_t   op;
		blbeu_kind_t kind;
		logic [2:0]  bitsel;
		logic        hs;
		logic [3:0]  rd_wait;
		logic [3:0]  wr_wait;
	} blbeu_cmd_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] program_status_word;
		logic [7:0] mem;
		logic       opbit;
	} blbeu_res_t;

endpackage : blbeu_pkg

// >>> blbeu_alu.sv
// Purpose: Combinational result of one bit or decimal adjust operation.
// Assumes: Inputs hold steady while the sequencer counts clocks.
// Notes:   The memory byte stands for short-direct, SFR and pointer-pair bytes.
`timescale 1ns/1ps
module blbeu_alu
	import blbeu_pkg::*;
(
	input  wire blbeu_pkg::blbeu_cmd_t cmd,
	input  wire logic [7:0]            acc,
	input  wire logic [7:0]            program_status_word,
	input  wire logic [7:0]            mem,
	output      blbeu_pkg::blbeu_res_t res
);

	logic [7:0] src;
	logic [7:0] tgt;
	logic       cy;
	logic       bitv;
	logic       wr_bit;
	logic [8:0] t;
	logic       lo_big;

	always_comb begin
		cy     = program_status_word[PSW_CY_BIT];
		src    = (cmd.kind == K_ACC) ? acc : (cmd.kind == K_PSW) ? program_status_word : mem;
		res.opbit = src[cmd.bitsel];
		res.acc = acc;
		res.program_status_word = program_status_word;
		res.mem = mem;
		wr_bit = 1'b0;
		bitv   = 1'b0;
		tgt    = src;
		t      = {1'b0, acc};
		lo_big = (acc[3:0] > 4'h9);
		unique case (cmd.op)
			OP_LOAD:  res.program_status_word[PSW_CY_BIT] = res.opbit;
			OP_AND:   res.program_status_word[PSW_CY_BIT] = cy & res.opbit;
			OP_OR:    res.program_status_word[PSW_CY_BIT] = cy | res.opbit;
			OP_XOR:   res.program_status_word[PSW_CY_BIT] = cy ^ res.opbit;
			OP_STORE: begin
				wr_bit = 1'b1;
				bitv   = cy;
			end
			OP_SET: begin
				wr_bit = 1'b1;
				bitv   = 1'b1;
			end
			OP_ADJA: begin
				if (program_status_word[PSW_AC_BIT] || lo_big) begin
					t = t + 9'h006;
				end
				if (cy || (acc > 8'h99)) begin
					t = t + 9'h060;
				end
				res.acc = t[7:0];
				res.program_status_word[PSW_CY_BIT] = cy | (acc > 8'h99) | t[8];
				res.program_status_word[PSW_AC_BIT] = lo_big;
				res.program_status_word[PSW_Z_BIT]  = (t[7:0] == 8'h00);
			end
			OP_ADJS: begin
				if (program_status_word[PSW_AC_BIT]) begin
					t = t - 9'h006;
				end
				if (cy) begin
					t = t - 9'h060;
				end
				res.acc = t[7:0];
				res.program_status_word[PSW_AC_BIT] = program_status_word[PSW_AC_BIT] & (acc[3:0] < 4'h6);
				res.program_status_word[PSW_Z_BIT]  = (t[7:0] == 8'h00);
			end
		endcase
		tgt[cmd.bitsel] = bitv;
		if (wr_bit) begin
			unique case (cmd.kind)
				K_ACC:   res.acc = tgt;
				K_PSW:   res.program_status_word = tgt;
				default: res.mem = tgt;
			endcase
		end
	end

endmodule : blbeu_alu

// >>> blbeu_top.sv
// Purpose: APB-reached bit logic and decimal adjust execution unit.
// Assumes: Software loads operands, writes a command, polls busy.
// Notes:   Operand registers are locked while an operation runs.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module blbeu_top
	import blbeu_pkg::*;
#(
	parameter logic [7:0] EXT_FETCH_CLKS = 8'h00
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	output      logic        busy,
	output      logic        done
);

	import blbeu_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	function automatic logic is_mapped(logic [7:0] a);
		is_mapped = (a == OFS_CMD) || (a == OFS_ACC) || (a == OFS_PSW) ||
			(a == OFS_MEM) || (a == OFS_STAT) || (a == OFS_CLK);
	endfunction : is_mapped

	function automatic blbeu_cmd_t cmd_of(logic [31:0] w);
		blbeu_cmd_t c;
		c.op      = blbeu_op_t'(w[CMD_OP_LSB +: 3]);
		c.kind    = blbeu_kind_t'(w[CMD_KIND_LSB +: 3]);
		c.bitsel  = w[CMD_BIT_LSB +: 3];
		c.hs      = w[CMD_HS_BIT];
		c.rd_wait = w[CMD_RDW_LSB +: 4];
		c.wr_wait = w[CMD_WRW_LSB +: 4];
		cmd_of = c;
	endfunction : cmd_of

	function automatic logic cmd_ok(blbeu_cmd_t c);
		cmd_ok = (c.op == OP_ADJA) || (c.op == OP_ADJS) || (c.kind <= K_HL);
	endfunction : cmd_ok

	// Total CPU clocks for one operation; SFR and status-word operands never
	// sit in high-speed RAM, so their flag is ignored.
	function automatic logic [7:0] clocks_of(blbeu_cmd_t c, logic xf);
		logic [7:0] n2;
		logic [7:0] m2;
		logic [7:0] b;
		n2 = {3'h0, c.rd_wait, 1'b0};
		m2 = {3'h0, c.wr_wait, 1'b0};
		b  = CLK_SHORT;
		if ((c.op == OP_ADJA) || (c.op == OP_ADJS)) begin
			b = CLK_SHORT;
		end else if (c.kind == K_ACC) begin
			b = CLK_SHORT;
		end else if (c.op == OP_STORE) begin
			unique case (c.kind)
				K_SADDR: b = c.hs ? CLK_HS : CLK_STORE;
				K_HL:    b = c.hs ? CLK_HS : CLK_STORE + n2 + m2;
				default: b = CLK_STORE;
			endcase
		end else if (c.op == OP_SET) begin
			unique case (c.kind)
				K_SADDR: b = c.hs ? CLK_SHORT : CLK_HS;
				K_PSW:   b = CLK_HS;
				K_HL:    b = c.hs ? CLK_HS : CLK_STORE + n2 + m2;
				default: b = CLK_STORE;
			endcase
		end else begin
			unique case (c.kind)
				K_SADDR: b = c.hs ? CLK_HS : CLK_EXT;
				K_HL:    b = c.hs ? CLK_HS : CLK_EXT + n2;
				default: b = CLK_EXT;
			endcase
		end
		clocks_of = xf ? b + EXT_FETCH_CLKS : b;
	endfunction : clocks_of

	function automatic logic [3:0] bytes_of(blbeu_cmd_t c);
		if ((c.op == OP_ADJA) || (c.op == OP_ADJS) || (c.kind == K_ACC) ||
			(c.kind == K_HL)) begin
			bytes_of = LEN_SHORT;
		end else if ((c.op == OP_SET) && (c.kind != K_SFR)) begin
			bytes_of = LEN_SHORT;
		end else begin
			bytes_of = LEN_LONG;
		end
	endfunction : bytes_of

	////////////////////////////////////////////////////////////////////////////
	// State.

	blbeu_state_t state_q;
	blbeu_cmd_t   cmd_q;
	blbeu_res_t   res;
	logic [7:0]   acc_q;
	logic [7:0]   psw_q;
	logic [7:0]   mem_q;
	logic [2:0]   sel_q;
	logic         xf_q;
	logic [7:0]   cnt_q;
	logic [7:0]   total_q;
	logic [3:0]   len_q;
	logic         bad_q;
	logic [6:0]   div_q;
	logic [7:0]   div_lim;
	logic         tick;
	logic         acc_ph;
	logic         wr_go;
	logic         rd_go;
	logic         start;
	logic         fin;
	logic         locked;
	logic         wr_err;
	logic [31:0]  rd_word;
	blbeu_cmd_t   wcmd;

	assign wcmd    = cmd_of(pwdata);
	assign acc_ph  = psel && penable;
	assign rd_go   = acc_ph && !pready;
	assign wr_go   = acc_ph && pready && pwrite;
	assign locked  = (state_q == ST_EXEC);
	assign wr_err  = !is_mapped(paddr) || (locked && (paddr != OFS_STAT)) ||
		((paddr == OFS_CMD) && !cmd_ok(wcmd));
	assign start   = wr_go && !wr_err && (paddr == OFS_CMD);
	assign div_lim = (8'h01 << sel_q) - 8'h01;
	assign tick    = (div_q == div_lim[6:0]);
	assign fin     = locked && tick && (cnt_q == 8'h00);

	blbeu_alu u_alu (
		.cmd (cmd_q),
		.acc (acc_q),
		.program_status_word (psw_q),
		.mem (mem_q),
		.res (res)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait cycle; writes land at the edge that samples pready.

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (paddr)
			OFS_CMD:  rd_word = {8'h00, cmd_q.wr_wait, cmd_q.rd_wait, 3'h0,
				cmd_q.hs, 1'b0, cmd_q.bitsel, 1'b0, cmd_q.kind, 1'b0, cmd_q.op};
			OFS_ACC:  rd_word = {24'h000000, acc_q};
			OFS_PSW:  rd_word = {24'h000000, psw_q};
			OFS_MEM:  rd_word = {24'h000000, mem_q};
			OFS_STAT: rd_word = {12'h000, len_q, total_q, 6'h00, bad_q, busy};
			OFS_CLK:  rd_word = {27'h0000000, xf_q, 1'b0, sel_q};
			default:  rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= rd_go;
			pslverr <= rd_go && (pwrite ? wr_err : !is_mapped(paddr));
			if (rd_go && !pwrite) begin
				prdata <= rd_word;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= SEL_RST;
			xf_q  <= 1'b0;
		end else if (wr_go && !wr_err && (paddr == OFS_CLK)) begin
			sel_q <= pwdata[CLK_SEL_LSB +: 3];
			xf_q  <= pwdata[CLK_XF_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// CPU clock divider and instruction sequencer.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 7'h00;
		end else if (start || tick) begin
			div_q <= 7'h00;
		end else begin
			div_q <= div_q + 7'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cmd_q   <= '0;
			cnt_q   <= 8'h00;
			total_q <= 8'h00;
			len_q   <= 4'h0;
			busy    <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= fin;
			unique case (state_q)
				ST_IDLE: if (start) begin
					state_q <= ST_EXEC;
					cmd_q   <= wcmd;
					total_q <= clocks_of(wcmd, xf_q);
					cnt_q   <= clocks_of(wcmd, xf_q) - 8'h01;
					len_q   <= bytes_of(wcmd);
					busy    <= 1'b1;
				end
				ST_EXEC: if (fin) begin
					state_q <= ST_IDLE;
					busy    <= 1'b0;
				end else if (tick) begin
					cnt_q <= cnt_q - 8'h01;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bad_q <= 1'b0;
		end else if (wr_go && (paddr == OFS_CMD)) begin
			bad_q <= wr_err;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Operand and flag registers; results commit at the last CPU clock.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= ACC_RST;
			psw_q <= PSW_RST;
			mem_q <= MEM_RST;
		end else if (fin) begin
			acc_q <= res.acc;
			psw_q <= res.program_status_word;
			mem_q <= res.mem;
		end else if (wr_go && !wr_err) begin
			if (paddr == OFS_ACC) begin
				acc_q <= pwdata[7:0];
			end
			if (paddr == OFS_PSW) begin
				psw_q <= pwdata[7:0];
			end
			if (paddr == OFS_MEM) begin
				mem_q <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_start;
		start;
	endsequence

	sequence s_fin;
		fin;
	endsequence

	property p_div_hold;
		@(posedge pclk) disable iff (!presetn)
		(locked && !tick && !fin) |=> $stable(cnt_q);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("count moved off tick");

	property p_hl_read_clks;
		@(posedge pclk) disable iff (!presetn)
		s_start ##0 (wcmd.kind == K_HL && !wcmd.hs && !xf_q &&
			(wcmd.op == OP_LOAD || wcmd.op == OP_AND || wcmd.op == OP_XOR))
		|=> total_q == 8'd14 + {3'h0, cmd_q.rd_wait, 1'b0};
	endproperty
	a_hl_read_clks: assert property (p_hl_read_clks) else $error("bad 14+2n");

	property p_hl_rmw_clks;
		@(posedge pclk) disable iff (!presetn)
		s_start ##0 (wcmd.kind == K_HL && !wcmd.hs && !xf_q && wcmd.op == OP_STORE)
		|=> total_q == 8'd16 + {3'h0, cmd_q.rd_wait, 1'b0} +
			{3'h0, cmd_q.wr_wait, 1'b0};
	endproperty
	a_hl_rmw_clks: assert property (p_hl_rmw_clks) else $error("bad 16+2n+2m");

	property p_saddr_clks;
		@(posedge pclk) disable iff (!presetn)
		s_start ##0 (wcmd.kind == K_SADDR && wcmd.op == OP_AND && !xf_q)
		|=> total_q == (cmd_q.hs ? 8'd12 : 8'd14) && len_q == 4'd3;
	endproperty
	a_saddr_clks: assert property (p_saddr_clks) else $error("bad and timing");

	property p_adj_len;
		@(posedge pclk) disable iff (!presetn)
		s_start ##0 (wcmd.op == OP_ADJA && !xf_q && sel_q == 3'h0)
		|=> (total_q == 8'd8 && len_q == 4'd2) ##7 s_fin;
	endproperty
	a_adj_len: assert property (p_adj_len) else $error("adjust not 8 clocks");

	property p_and_cy;
		@(posedge pclk) disable iff (!presetn)
		s_fin ##0 (cmd_q.op == OP_AND)
		|=> psw_q[PSW_CY_BIT] == ($past(psw_q[PSW_CY_BIT]) & $past(res.opbit));
	endproperty
	a_and_cy: assert property (p_and_cy) else $error("and carry wrong");

	property p_acc_and_clks;
		@(posedge pclk) disable iff (!presetn)
		s_start ##0 (wcmd.kind == K_ACC && wcmd.op == OP_AND && !xf_q)
		|=> total_q == 8'd8 && len_q == 4'd2;
	endproperty
	a_acc_and_clks: assert property (p_acc_and_clks) else $error("acc and timing");

	property p_store_bit;
		@(posedge pclk) disable iff (!presetn)
		s_fin ##0 (cmd_q.op == OP_STORE && cmd_q.kind == K_ACC)
		|=> acc_q[cmd_q.bitsel] == $past(psw_q[PSW_CY_BIT]);
	endproperty
	a_store_bit: assert property (p_store_bit) else $error("transfer bit wrong");

	property p_set_mem;
		@(posedge pclk) disable iff (!presetn)
		s_fin ##0 (cmd_q.op == OP_SET && cmd_q.kind == K_HL)
		|=> mem_q == ($past(mem_q) | (8'h01 << cmd_q.bitsel));
	endproperty
	a_set_mem: assert property (p_set_mem) else $error("set bit wrong");

endmodule : blbeu_top

// >>> blbeu_apb_master.sv
// Purpose: APB master model standing in for the CPU side of the execution unit.
// Assumes: One transfer at a time; pready is sampled only at rising edges.
// Notes:   Every request signal changes by non-blocking assignment after an edge.
`timescale 1ns/1ps
module blbeu_apb_master (
	input  wire logic        pclk,
	output      logic [7:0]  paddr,
	output      logic        psel,
	output      logic        penable,
	output      logic        pwrite,
	output      logic [31:0] pwdata,
	input  wire logic        pready,
	output      logic        hung
);
	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		hung = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// The request is held until pready is seen high; a slave that never answers
	// is reported through hung instead of stalling the run forever.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1) hung <= 1'b1;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : blbeu_apb_master

// >>> test_blbeu_top.sv
// Purpose: Self-checking bench for the bit logic and decimal adjust unit.
// Assumes: Answers arrive in request order; expectations wait in a queue.
// Notes:   Operands come from an eight-bit shift register seeded with 72.
`timescale 1ns/1ps
module test_blbeu_top;
	import blbeu_pkg::*;
	localparam logic [7:0] EXTF = 8'h03;
	localparam logic [2:0] PB [3] = '{3'h0, 3'h4, 3'h6};
	typedef struct {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic        err;
	} blbeu_exp_t;
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic        done;
	logic        hung;
	blbeu_exp_t  expq [$];
	blbeu_exp_t  mon_e;
	int          err_count;
	int          compares;
	logic [7:0]  seed;
	logic [7:0]  m_acc;
	logic [7:0]  m_psw;
	logic [7:0]  m_mem;
	logic [2:0]  m_sel;
	logic        m_ext;
	int          m_t;
	int          m_len;
	int          m_cyc;
	time         m_t0;

	blbeu_top #(.EXT_FETCH_CLKS(EXTF)) u_blbeu_top (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .done(done));
	blbeu_apb_master u_blbeu_apb_master (.pclk(pclk), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .hung(hung));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	function automatic logic [7:0] rnd();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction : rnd

	function automatic int clocks(input int op, input int k, input logic hs, input int n,
			input int w);
		if (op >= 6 || k == 2) return 8;
		if (k == 4) return hs ? 12 : (op == 0 || (op > 1 && op < 5)) ? 14 + 2 * n
			: 16 + 2 * n + 2 * w;
		if (op == 5) return (k == 0) ? (hs ? 8 : 12) : (k == 3) ? 12 : 16;
		if (op == 1) return (k == 0 && hs) ? 12 : 16;
		return (k == 0 && hs) ? 12 : 14;
	endfunction : clocks

	function automatic logic [31:0] stat_exp(input logic refused);
		return {12'h000, 4'(m_len), 8'(m_t), 6'h00, refused, 1'b0};
	endfunction : stat_exp

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
		expq.push_back('{1'b1, a, 32'h0, err});
		u_blbeu_apb_master.xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
		expq.push_back('{1'b0, a, d, err});
		u_blbeu_apb_master.xfer(1'b0, a, 32'h0);
	endtask : rd

	always @(posedge hung) begin
		err_count++;
		conclude();
	end

	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (expq.size() == 0) begin
				check("unexpected answer", 32'h0, 32'h1);
			end else begin
				mon_e = expq.pop_front();
				check($sformatf("pslverr@%h", mon_e.a), {31'h0, mon_e.err}, {31'h0, pslverr});
				if (!mon_e.wr) check($sformatf("prdata@%h", mon_e.a), mon_e.d, prdata);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// The model state is updated here, before the command is sent.
	task automatic run_start(input int op, input int k, input logic [2:0] b, input logic hs,
			input int n, input int w);
		logic [7:0] tg;
		logic       cy;
		logic [8:0] r;
		tg = (k == 2) ? m_acc : (k == 3) ? m_psw : m_mem;
		cy = m_psw[PSW_CY_BIT];
		r = 9'h000;
		wr(OFS_ACC, {24'h0, m_acc}, 1'b0);
		wr(OFS_PSW, {24'h0, m_psw}, 1'b0);
		wr(OFS_MEM, {24'h0, m_mem}, 1'b0);
		case (op)
			0: cy = tg[b];
			1: tg[b] = cy;
			2: cy = cy & tg[b];
			3: cy = cy | tg[b];
			4: cy = cy ^ tg[b];
			5: tg[b] = 1'b1;
			6: begin
				r = {1'b0, m_acc} + ((m_psw[PSW_AC_BIT] || m_acc[3:0] > 4'h9) ? 9'h006 : 9'h000)
					+ ((cy || m_acc > 8'h99) ? 9'h060 : 9'h000);
				cy = cy | (m_acc > 8'h99) | r[8];
				m_psw[PSW_AC_BIT] = (m_acc[3:0] > 4'h9);
			end
			default: begin
				r = {1'b0, m_acc} - (m_psw[PSW_AC_BIT] ? 9'h006 : 9'h000)
					- (cy ? 9'h060 : 9'h000);
				m_psw[PSW_AC_BIT] = m_psw[PSW_AC_BIT] & (m_acc[3:0] < 4'h6);
			end
		endcase
		if (op >= 6) begin
			m_acc = r[7:0];
			m_psw[PSW_Z_BIT] = (r[7:0] == 8'h00);
		end else if (k == 2) m_acc = tg;
		else if (k == 3) m_psw = tg;
		else m_mem = tg;
		if (op != 1 && op != 5) m_psw[PSW_CY_BIT] = cy;
		m_t = clocks(op, k, hs, n, w) + (m_ext ? int'(EXTF) : 0);
		m_len = (op >= 6 || k == 2 || k == 4 || (op == 5 && (k == 0 || k == 3))) ? 2 : 3;
		m_cyc = m_t << m_sel;
		wr(OFS_CMD, (32'(op) << CMD_OP_LSB) | (32'(k) << CMD_KIND_LSB) | (32'(b) << CMD_BIT_LSB)
			| (32'(hs) << CMD_HS_BIT) | (32'(n) << CMD_RDW_LSB) | (32'(w) << CMD_WRW_LSB), 1'b0);
		m_t0 = $time;
	endtask : run_start

	task automatic run_end();
		int   k;
		int   el;
		logic seen;
		k = 0;
		seen = 1'b0;
		do begin
			@(posedge pclk);
			#1;
			k++;
			seen = seen | (done === 1'b1);
		end while (busy !== 1'b0 && k < 4000);
		el = int'(($time - m_t0) / 8);
		if (k >= 4000) begin
			err_count++;
			conclude();
		end
		repeat (2) begin
			@(posedge pclk);
			#1;
			seen = seen | (done === 1'b1);
		end
		check("cycles", m_cyc, el);
		check("done", 32'h1, {31'h0, seen});
		rd(OFS_ACC, {24'h0, m_acc}, 1'b0);
		rd(OFS_PSW, {24'h0, m_psw}, 1'b0);
		rd(OFS_MEM, {24'h0, m_mem}, 1'b0);
		rd(OFS_STAT, stat_exp(1'b0), 1'b0);
	endtask : run_end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] r;
		logic [2:0] b;
		presetn = 1'b0;
		err_count = 0;
		compares = 0;
		seed = 8'd72;
		{m_acc, m_psw, m_mem, m_sel, m_ext} = '0;
		m_t = 0;
		m_len = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_ACC, {24'h0, ACC_RST}, 1'b0);
		rd(OFS_PSW, {24'h0, PSW_RST}, 1'b0);
		rd(OFS_MEM, {24'h0, MEM_RST}, 1'b0);
		rd(OFS_CLK, {29'h0, SEL_RST}, 1'b0);
		rd(OFS_STAT, 32'h0, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
		wr(8'h18, 32'hFFFF_FFFF, 1'b1);
		for (int op = 0; op < 8; op++) for (int k = 0; k < 5; k++) for (int i = 0; i < 2; i++) begin
			if (op < 6 || k < 2) begin
				m_acc = rnd();
				m_psw = rnd() & 8'h51;
				m_mem = rnd();
				r = rnd();
				b = (k == 3) ? PB[rnd() % 8'd3] : r[7:5];
				run_start(op, (op < 6) ? k : 0, b, r[0], int'(r[2:1]), int'(r[4:3]));
				run_end();
			end
		end
		m_sel = 3'h2;
		m_ext = 1'b1;
		wr(OFS_CLK, (32'h1 << CLK_XF_BIT) | 32'h2, 1'b0);
		run_start(0, 0, 3'h3, 1'b0, 0, 0);
		wr(OFS_ACC, 32'h0000_005A, 1'b1);
		rd(OFS_CLK, (32'h1 << CLK_XF_BIT) | 32'h2, 1'b0);
		run_end();
		m_sel = 3'h0;
		m_ext = 1'b0;
		wr(OFS_CLK, 32'h0, 1'b0);
		wr(OFS_CMD, (32'h2 << CMD_OP_LSB) | (32'h5 << CMD_KIND_LSB), 1'b1);
		rd(OFS_STAT, stat_exp(1'b1), 1'b0);
		repeat (3) @(posedge pclk);
		check("queue", 32'h0, expq.size());
		conclude();
	end
endmodule : test_blbeu_top
